//--- design/cpe_pkg.sv
/*
  constants for the converter power and channel enable register bank.
  assumes an AXI4-Lite host port, one clock aclk, synchronous aresetn.
*/
// Summary of operation
// - pin scope field [4:3]: 00 ignore pin, 01 clocks, 10 +bias, 11 +master bias
// - power bit 7 turns calibration analog blocks on; zero powers them down
// - power bit 6 runs calibration clock and digital logic; zero stops them
// - power bit 5 switches on two extra noise-reduction channels
// - power bit 2 enables the converter master bias block
// - power bit 1 runs the first channel's converter clock
// - power bit 0 powers the first channel's analog front end
// - low enable register bit n gates sampling clock of channel n, 0..7
// - high enable register bit n gates sampling clock of channel n+8
package cpe_pkg;
  // offsets are register indices; byte address is index << CPE_IDX_SHIFT
  localparam int CPE_AW = 14;
  localparam logic [11:0] CPE_OFS_PWR = 12'hB90;
  localparam logic [11:0] CPE_OFS_CHLO = 12'hB91;
  localparam logic [11:0] CPE_OFS_CHHI = 12'hB92;
  localparam logic [11:0] CPE_OFS_GAIN = 12'hB94;
  localparam logic [11:0] CPE_OFS_CAP = 12'hB95;
  localparam logic [11:0] CPE_OFS_DITH1 = 12'hB99;
  localparam logic [11:0] CPE_OFS_DITH2 = 12'hB9A;
  localparam logic [11:0] CPE_OFS_STAT = 12'hBA0;
  localparam int CPE_IDX_SHIFT = 2;
  localparam int CPE_BIT_CAL_ANA = 7;
  localparam int CPE_BIT_CAL_CLK = 6;
  localparam int CPE_BIT_EXTRA = 5;
  localparam int CPE_PIN_LSB = 3;
  localparam int CPE_BIT_BIAS = 2;
  localparam int CPE_BIT_CLK0 = 1;
  localparam int CPE_BIT_FE0 = 0;
  localparam logic [7:0] CPE_TRIM_MASK = 8'h3F;
  localparam logic [7:0] CPE_RST_BYTE = 8'h00;
  localparam logic [7:0] CPE_RST_DITH1 = 8'h00;
  localparam logic [1:0] CPE_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPE_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CPE_PIN_OFF = 2'h0,
    CPE_PIN_CLK = 2'h1,
    CPE_PIN_BIAS = 2'h2,
    CPE_PIN_ALL = 2'h3
  } cpe_pin_e;
endpackage

//--- design/cpe_wr_if.sv
/*
  internal write port between bus slave and register store.
  assumes the slave and store share aclk.
*/
`timescale 1ns/1ps
interface cpe_wr_if;
  logic we;
  logic [11:0] addr;
  logic [7:0] data;
  logic hit;
  modport src (output we, output addr, output data, input hit);
  modport dst (input we, input addr, input data, output hit);
endinterface

//--- design/cpe_regs.sv
/*
  register store: the seven bytes of the bank, byte wide writes.
  assumes one write strobe per cycle from the bus slave.
*/
`timescale 1ns/1ps
module cpe_regs
  import cpe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  cpe_wr_if.dst wr,
  output logic [55:0] bytes_q
);
  typedef struct packed {
    logic [7:0] pwr, chlo, chhi, gain, cap, d1, d2;
  } cpe_st_s;
  cpe_st_s st_reg, st_next;

  // address hit for the write port
  always_comb begin
    unique case (wr.addr)
      CPE_OFS_PWR, CPE_OFS_CHLO, CPE_OFS_CHHI, CPE_OFS_GAIN,
      CPE_OFS_CAP, CPE_OFS_DITH1, CPE_OFS_DITH2: wr.hit = 1'b1;
      default: wr.hit = 1'b0;
    endcase
  end

  // next state from write strobe
  always_comb begin
    st_next = st_reg;
    if (wr.we) begin
      unique case (wr.addr)
        CPE_OFS_PWR: st_next.pwr = wr.data;
        CPE_OFS_CHLO: st_next.chlo = wr.data;
        CPE_OFS_CHHI: st_next.chhi = wr.data;
        CPE_OFS_GAIN: st_next.gain = wr.data & CPE_TRIM_MASK;
        CPE_OFS_CAP: st_next.cap = wr.data & CPE_TRIM_MASK;
        CPE_OFS_DITH1: st_next.d1 = wr.data;
        CPE_OFS_DITH2: st_next.d2 = wr.data;
        default: st_next = st_reg;
      endcase
    end
  end

  // register the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{CPE_RST_BYTE, CPE_RST_BYTE, CPE_RST_BYTE, CPE_RST_BYTE,
                 CPE_RST_BYTE, CPE_RST_DITH1, CPE_RST_BYTE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign bytes_q = st_reg;

  // reserved trim bits never hold a one
  a_trim_reserved_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.gain[7:6] == 2'h0) && (st_reg.cap[7:6] == 2'h0))
    else $error("trim reserved bits not zero");
endmodule

//--- design/cpe_gate.sv
/*
  power gating decode: turns the shutdown pin scope into kill signals for the enables.
  assumes shutdown_pin is synchronous to aclk.
*/
`timescale 1ns/1ps
module cpe_gate
  import cpe_pkg::*;
(
  input wire logic [7:0] pwr,
  input wire logic shutdown_pin,
  output logic pin_kill_clk,
  output logic pin_kill_bias,
  output logic pin_kill_master
);
  cpe_pin_e shutdown_pin_scope;
  // scope field selects how far the pin reaches
  always_comb begin
    shutdown_pin_scope = cpe_pin_e'(pwr[CPE_PIN_LSB +: 2]);
    pin_kill_clk = 1'b0;
    pin_kill_bias = 1'b0;
    pin_kill_master = 1'b0;
    unique case (shutdown_pin_scope)
      CPE_PIN_OFF: pin_kill_clk = 1'b0;
      CPE_PIN_CLK: pin_kill_clk = shutdown_pin;
      CPE_PIN_BIAS: begin
        pin_kill_clk = shutdown_pin;
        pin_kill_bias = shutdown_pin;
      end
      CPE_PIN_ALL: begin
        pin_kill_clk = shutdown_pin;
        pin_kill_bias = shutdown_pin;
        pin_kill_master = shutdown_pin;
      end
    endcase
  end
endmodule

//--- design/cpe_top.sv
/*
  converter power and channel clock enable bank with AXI4-Lite slave.
  assumes one clock aclk at 100 MHz, synchronous active-low aresetn,
  and a shutdown pin already synchronous to aclk.
*/
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module cpe_top
  import cpe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpe_pkg::CPE_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cpe_pkg::CPE_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shutdown_pin,
  output logic calib_analog_on,
  output logic calib_clock_on,
  output logic extra_channels_on,
  output logic master_bias_on,
  output logic first_channel_clock_on,
  output logic first_front_end_on,
  output logic [15:0] channel_clock_on,
  output logic [5:0] gain_trim,
  output logic [5:0] cap_trim,
  output logic [7:0] dither_current_one_code,
  output logic [7:0] dither_current_two_code
);
  typedef struct packed {
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [7:0] pwr_q;
    logic [15:0] ch_q;
  } cpe_bus_s;

  cpe_bus_s s_reg, s_next;
  cpe_wr_if wr ();
  logic [55:0] bytes_q;
  logic [7:0] r_pwr, r_chlo, r_chhi, r_gain, r_cap, r_d1, r_d2;
  logic kill_clk, kill_bias, kill_master;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [11:0] rd_idx;
  logic [7:0] status_byte;

  cpe_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr(wr),
    .bytes_q(bytes_q)
  );

  cpe_gate u_gate (
    .pwr(r_pwr),
    .shutdown_pin(shutdown_pin),
    .pin_kill_clk(kill_clk),
    .pin_kill_bias(kill_bias),
    .pin_kill_master(kill_master)
  );

  assign {r_pwr, r_chlo, r_chhi, r_gain, r_cap, r_d1, r_d2} = bytes_q;

  // write strobe fires once address and data are both held, no response is pending and lane 0 is strobed;
  // each register sits in the low byte lane of its own word
  always_comb begin
    wr.we = s_reg.aw_full && s_reg.w_full && !s_reg.b_valid
      && s_reg.w_strb[0];
    wr.addr = s_reg.aw_addr;
    wr.data = s_reg.w_data[7:0];
  end

  // live state visible to software
  assign status_byte = {3'h0, shutdown_pin, kill_master, kill_bias,
                        kill_clk, 1'b0};

  // read decode by register index, byte in the low lane of the word
  assign rd_idx = s_axi_araddr[CPE_AW-1:CPE_IDX_SHIFT];
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      CPE_OFS_PWR: rd_byte = r_pwr;
      CPE_OFS_CHLO: rd_byte = r_chlo;
      CPE_OFS_CHHI: rd_byte = r_chhi;
      CPE_OFS_GAIN: rd_byte = r_gain & CPE_TRIM_MASK;
      CPE_OFS_CAP: rd_byte = r_cap & CPE_TRIM_MASK;
      CPE_OFS_DITH1: rd_byte = r_d1;
      CPE_OFS_DITH2: rd_byte = r_d2;
      CPE_OFS_STAT: rd_byte = status_byte;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // handshakes: accept each channel while its holding slot is empty
  assign s_axi_awready = !s_reg.aw_full;
  assign s_axi_wready = !s_reg.w_full;
  assign s_axi_arready = !s_reg.r_valid;

  // bus state and gated output enables
  always_comb begin
    s_next = s_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr[CPE_AW-1:CPE_IDX_SHIFT]; // index only
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.b_valid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.b_valid = 1'b1;
      s_next.b_resp = (wr.hit || s_reg.aw_addr == CPE_OFS_STAT) ?
        CPE_RESP_OKAY : CPE_RESP_SLVERR;
    end
    if (s_reg.b_valid && s_axi_bready) begin
      s_next.b_valid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.r_valid = 1'b1;
      s_next.r_data = {24'h0, rd_byte};
      s_next.r_resp = rd_hit ? CPE_RESP_OKAY : CPE_RESP_SLVERR;
    end else if (s_reg.r_valid && s_axi_rready) begin
      s_next.r_valid = 1'b0;
    end
    // power enables other than calibration analog, each dropped by the pin only within its scope
    s_next.pwr_q = 8'h00;
    s_next.pwr_q[CPE_BIT_CAL_ANA] = r_pwr[CPE_BIT_CAL_ANA];
    s_next.pwr_q[CPE_BIT_CAL_CLK] =
      r_pwr[CPE_BIT_CAL_CLK] && !kill_clk;
    s_next.pwr_q[CPE_BIT_EXTRA] =
      r_pwr[CPE_BIT_EXTRA] && !kill_clk;
    s_next.pwr_q[CPE_BIT_BIAS] =
      r_pwr[CPE_BIT_BIAS] && !kill_master;
    s_next.pwr_q[CPE_BIT_CLK0] =
      r_pwr[CPE_BIT_CLK0] && !kill_clk;
    s_next.pwr_q[CPE_BIT_FE0] =
      r_pwr[CPE_BIT_FE0] && !kill_bias;
    // per-channel sampling clocks
    s_next.ch_q = {r_chhi, r_chlo} & {16{!kill_clk}};
  end

  // register the bus state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs from flip-flops
  assign s_axi_bvalid = s_reg.b_valid;
  assign s_axi_bresp = s_reg.b_resp;
  assign s_axi_rvalid = s_reg.r_valid;
  assign s_axi_rdata = s_reg.r_data;
  assign s_axi_rresp = s_reg.r_resp;
  assign calib_analog_on = s_reg.pwr_q[CPE_BIT_CAL_ANA];
  assign calib_clock_on = s_reg.pwr_q[CPE_BIT_CAL_CLK];
  assign extra_channels_on = s_reg.pwr_q[CPE_BIT_EXTRA];
  assign master_bias_on = s_reg.pwr_q[CPE_BIT_BIAS];
  assign first_channel_clock_on = s_reg.pwr_q[CPE_BIT_CLK0];
  assign first_front_end_on = s_reg.pwr_q[CPE_BIT_FE0];
  assign channel_clock_on = s_reg.ch_q;
  assign gain_trim = r_gain[5:0];
  assign cap_trim = r_cap[5:0];
  assign dither_current_one_code = r_d1;
  assign dither_current_two_code = r_d2;

  // pin scope: how far the shutdown pin reaches
  a_pin_ignored: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (r_pwr[4:3] == 2'h0) |=> (calib_clock_on == $past(r_pwr[6])))
    else $error("pin acted while scope is off");
  a_master_scope: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (shutdown_pin && r_pwr[4:3] == 2'h3) |=> !master_bias_on)
    else $error("master bias not dropped in full scope");
  a_clk_scope: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (shutdown_pin && r_pwr[4:3] != 2'h0) |=>
      (channel_clock_on == 16'h0000 && !calib_clock_on
      && !first_channel_clock_on && !extra_channels_on))
    else $error("clock path not dropped by the pin");
  a_bias_scope: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (shutdown_pin && r_pwr[4]) |=> !first_front_end_on)
    else $error("front end not dropped by the pin");
  a_clk_only_scope: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (r_pwr[4:3] == 2'h1) |=> (first_front_end_on == $past(r_pwr[0])
      && master_bias_on == $past(r_pwr[2])))
    else $error("clock-only scope reached the bias");

  // each power bit outside the scope field drives its own enable a cycle later
  a_cal_ana_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 calib_analog_on == $past(r_pwr[7]))
    else $error("calibration analog enable wrong");
  a_cal_ana_ungated: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (shutdown_pin && r_pwr[7]) |=> calib_analog_on)
    else $error("calibration analog dropped by the pin");
  a_cal_clk_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !r_pwr[6] |=> !calib_clock_on)
    else $error("calibration clock ran while disabled");
  a_cal_clk_on: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (r_pwr[6] && !kill_clk) |=> calib_clock_on)
    else $error("calibration clock not on");
  a_extra_on: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (r_pwr[5] && !kill_clk) |=> extra_channels_on)
    else $error("extra channels not on");
  a_extra_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !r_pwr[5] |=> !extra_channels_on)
    else $error("extra channels on while disabled");
  a_bias_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!kill_master) |=> master_bias_on == $past(r_pwr[2]))
    else $error("bias enable wrong");
  a_bias_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !r_pwr[2] |=> !master_bias_on)
    else $error("bias on while disabled");
  a_clk0_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !r_pwr[1] |=> !first_channel_clock_on)
    else $error("first channel clock ran while disabled");
  a_clk0_on: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (r_pwr[1] && !kill_clk) |=> first_channel_clock_on)
    else $error("first channel clock not on");
  a_fe0_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!kill_bias) |=> first_front_end_on == $past(r_pwr[0]))
    else $error("front end enable wrong");
  a_fe0_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !r_pwr[0] |=> !first_front_end_on)
    else $error("front end on while disabled");

  // per-channel sampling clocks follow their enable bits
  a_chan_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !kill_clk |=> channel_clock_on[7:0] == $past(r_chlo))
    else $error("low channel clocks wrong");
  a_chan_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !kill_clk |=> channel_clock_on[15:8] == $past(r_chhi))
    else $error("high channel clocks wrong");

  // reserved trim bits never appear on the read bus
  a_trim_read_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready
      && (rd_idx == CPE_OFS_GAIN || rd_idx == CPE_OFS_CAP)) |=>
      (s_axi_rdata[7:6] == 2'h0))
    else $error("reserved trim bits read as one");

  // write channel: refusal while full, answer stands until taken
  a_aw_refuse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready)
    else $error("second address taken while one is held");
  a_w_refuse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_wvalid && s_axi_wready) |=> !s_axi_wready)
    else $error("second data taken while one is held");
  a_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid) |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_bvalid_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=>
      (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped or changed early");
  a_bvalid_drop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response repeated");

  // read channel: one answer per address, standing until taken
  a_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read data late");
  a_rvalid_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read data dropped or changed early");
  a_rvalid_drop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_rdata_lanes: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
    else $error("upper read lanes not zero");
  a_read_unmapped: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !rd_hit) |=>
      (s_axi_rresp == CPE_RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("unmapped read not refused");
  a_read_mapped: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_hit) |=>
      (s_axi_rresp == CPE_RESP_OKAY))
    else $error("mapped read refused");
  a_status_pin: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_idx == CPE_OFS_STAT) |=>
      (s_axi_rdata[4] == $past(shutdown_pin)))
    else $error("status pin level wrong");
endmodule

//--- dv/cpe_top_test.sv
/*
  self-checking bench for the power and channel clock enable bank.
  assumes cpe_top answers its AXI4-Lite port within a few cycles.
*/
`timescale 1ns/1ps
module cpe_top_test;
  import cpe_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pin = 1'b0;
  logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire [49:0] outs;
  int bad_count = 0;
  int compares = 0;
  int i, k;
  logic [7:0] m [7];
  logic [11:0] offs [7] = '{CPE_OFS_PWR, CPE_OFS_CHLO, CPE_OFS_CHHI,
    CPE_OFS_GAIN, CPE_OFS_CAP, CPE_OFS_DITH1, CPE_OFS_DITH2};
  logic [7:0] mask [7] = '{8'hFF, 8'hFF, 8'hFF, CPE_TRIM_MASK,
    CPE_TRIM_MASK, 8'hFF, 8'hFF};

  // 100 MHz clock
  always #5 aclk = ~aclk;

  cpe_top cpe_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .shutdown_pin(pin),
    .calib_analog_on(outs[49]), .calib_clock_on(outs[48]),
    .extra_channels_on(outs[47]), .master_bias_on(outs[46]),
    .first_channel_clock_on(outs[45]), .first_front_end_on(outs[44]),
    .channel_clock_on(outs[43:28]), .gain_trim(outs[27:22]),
    .cap_trim(outs[21:16]), .dither_current_one_code(outs[15:8]),
    .dither_current_two_code(outs[7:0]));

  // expected outputs from the model bytes and the pin level
  function automatic logic [49:0] exp_out(input logic p);
    logic [7:0] r;
    logic [1:0] sc;
    logic kc, kb, km;
    r = m[0];
    sc = r[CPE_PIN_LSB+:2];
    kc = p && sc != 2'h0;
    kb = p && sc[1];
    km = p && sc == 2'h3;
    return {r[CPE_BIT_CAL_ANA], r[CPE_BIT_CAL_CLK] & !kc,
      r[CPE_BIT_EXTRA] & !kc, r[CPE_BIT_BIAS] & !km, r[CPE_BIT_CLK0] & !kc,
      r[CPE_BIT_FE0] & !kb, {m[2], m[1]} & {16{!kc}}, m[3][5:0], m[4][5:0],
      m[5], m[6]};
  endfunction

  // status word: pin level and the reach of each kill for scope s
  function automatic logic [31:0] stat_exp(input logic p, input int s);
    return {27'h0, p, p && s == 3, p && s >= 2, p && s != 0, 1'b0};
  endfunction

  // model bytes as reset leaves them
  task automatic reset_model();
    for (int j = 0; j < 7; j++) m[j] = CPE_RST_BYTE;
    m[5] = CPE_RST_DITH1;
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [49:0] e,
      input logic [49:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a handshake that never completed ends the run
  task automatic guard(input logic ok);
    if (!ok) begin
      bad_count++;
      $display("wrong value handshake expected 1 seen 0");
      end_sim();
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] s, input logic [1:0] er);
    logic pa, pw, ta, tw;
    int c;
    pa = 1'b1;
    pw = 1'b1;
    c = 0;
    @(posedge aclk);
    awaddr <= {a, 2'h0};
    awvalid <= 1'b1;
    wdata <= {24'($urandom), d};
    wstrb <= s;
    wvalid <= 1'b1;
    while ((pa || pw) && c < 64) begin
      @(negedge aclk);
      ta = pa && awready === 1'b1;
      tw = pw && wready === 1'b1;
      @(posedge aclk);
      pa = pa && !ta;
      pw = pw && !tw;
      awvalid <= pa;
      wvalid <= pw;
      c++;
    end
    guard(!(pa || pw));
    bready <= 1'b1;
    ta = 1'b0;
    c = 0;
    while (!ta && c < 64) begin
      @(negedge aclk);
      ta = bvalid === 1'b1;
      c++;
    end
    guard(ta);
    chk("bresp", 50'(er), 50'(bresp));
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    logic ok;
    int c;
    ok = 1'b0;
    c = 0;
    @(posedge aclk);
    araddr <= {a, 2'h0};
    arvalid <= 1'b1;
    while (!ok && c < 64) begin
      @(negedge aclk);
      ok = arready === 1'b1;
      c++;
    end
    guard(ok);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    ok = 1'b0;
    c = 0;
    while (!ok && c < 64) begin
      @(negedge aclk);
      ok = rvalid === 1'b1;
      c++;
    end
    guard(ok);
    chk("rdata", 50'(ed), 50'(rdata));
    chk("rresp", 50'(er), 50'(rresp));
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // write one register and track it in the model
  task automatic wr_model(input int x, input logic [7:0] d,
      input logic [3:0] s);
    axi_wr(offs[x], d, s, CPE_RESP_OKAY);
    if (s[0]) m[x] = d & mask[x];
  endtask

  task automatic rd_model(input int x);
    axi_rd(offs[x], {24'h0, m[x]}, CPE_RESP_OKAY);
  endtask

  // set the pin, let registered outputs land, compare them all
  task automatic pin_chk(input logic v);
    @(posedge aclk);
    pin <= v;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("outputs", exp_out(v), outs);
  endtask

  initial begin
    k = $urandom(32'h156B);
    reset_model();
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    pin_chk(1'b0);
    for (i = 0; i < 7; i++) rd_model(i);
    $display("test reset values done");
    // random registers, strobes and pin level
    repeat (60) begin
      i = $urandom_range(6);
      wr_model(i, 8'($urandom), 4'($urandom));
      pin_chk(1'($urandom));
      rd_model(i);
    end
    $display("test random traffic done");
    // one power bit at a time, pin idle
    for (k = 0; k < 8; k++) begin
      wr_model(0, 8'(1 << k), 4'hF);
      pin_chk(1'b0);
    end
    $display("test power bits done");
    // every pin scope with all enables set
    wr_model(1, 8'hFF, 4'hF);
    wr_model(2, 8'hFF, 4'hF);
    wr_model(3, 8'hFF, 4'hF);
    rd_model(3);
    for (k = 0; k < 4; k++) begin
      wr_model(0, 8'hE7 | 8'(k << CPE_PIN_LSB), 4'hF);
      pin_chk(1'b1);
      axi_rd(CPE_OFS_STAT, stat_exp(1'b1, k), CPE_RESP_OKAY);
      pin_chk(1'b0);
      axi_rd(CPE_OFS_STAT, stat_exp(1'b0, k), CPE_RESP_OKAY);
    end
    $display("test pin scopes done");
    // unmapped places answer with an error and change nothing
    axi_wr(12'hB93, 8'h5A, 4'hF, CPE_RESP_SLVERR);
    axi_rd(12'hB93, 32'h0, CPE_RESP_SLVERR);
    axi_wr(12'hB9B, 8'hA5, 4'hF, CPE_RESP_SLVERR);
    axi_rd(12'hB9B, 32'h0, CPE_RESP_SLVERR);
    // status accepts a write with OKAY and the seven registers keep their values
    axi_wr(CPE_OFS_STAT, 8'hFF, 4'hF, CPE_RESP_OKAY);
    pin_chk(1'b0);
    for (i = 0; i < 7; i++) rd_model(i);
    $display("test unmapped done");
    // reset in mid-run returns every register to its reset value
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_model();
    pin_chk(1'b0);
    for (i = 0; i < 7; i++) rd_model(i);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
